// >>> pkg/hpc_params.svh
// Purpose: Named constants for the host parallel port
// Assumes: Included by bare name from the package, the properties and the bench
// Notes: CPU offsets are byte addresses on the memory-mapped side
`ifndef HPC_PARAMS_SVH
`define HPC_PARAMS_SVH

// CPU-side register byte addresses
`define HPC_OFS_PWR 32'h0288_0004
`define HPC_OFS_CTRL 32'h0288_0030
`define HPC_OFS_WADDR 32'h0288_0034
`define HPC_OFS_RADDR 32'h0288_0038

// Control register bit positions
`define HPC_BIT_FROMHOST 1
`define HPC_BIT_TOHOST 2
`define HPC_BIT_READY 3
`define HPC_BIT_DUAL 8
`define HPC_BIT_ASEL 11

// Access type select codes
`define HPC_AT_CTRL 2'h0
`define HPC_AT_DATAINC 2'h1
`define HPC_AT_ADDR 2'h2
`define HPC_AT_DATA 2'h3

// Reset values
`define HPC_RST_WORD 32'h0000_0000
`define HPC_RST_PINS 9'h1ff

// Address step for auto-increment, strap settle count, FIFO depth
`define HPC_ADDR_STEP 32'h0000_0004
`define HPC_STRAP_SETTLE 3'h5
`define HPC_FIFO_DEPTH 8

`endif

// >>> pkg/hpc_pkg.sv
// Purpose: Types shared by the host parallel port modules
// Assumes: hpc_params.svh on the include path
// Notes: Constants live in the header, types here
`include "hpc_params.svh"
package hpc_pkg;

  // One buffered host write toward internal memory
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
  } hpc_wr_t;

  // Cycle qualifiers latched at the start of a host access
  typedef struct packed {
    logic [1:0] accessType;
    logic readWrite;
    logic halfword;
  } hpc_qual_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_READY = 2'b10
  } hpc_state_t;

endpackage

// >>> rtl/hpc_sync.sv
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Inputs are asynchronous to clk
// Notes: Output follows once stages two and three agree
`timescale 1ns/1ps
module hpc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Pins in, filtered levels out
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] levelOut
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] out_ff;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_ff <= RST;
      s2_ff <= RST;
      s3_ff <= RST;
    end else begin
      s1_ff <= pinIn;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      out_ff <= RST;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_ff[i] == s3_ff[i]) begin
          out_ff[i] <= s3_ff[i];
        end
      end
    end
  end

  assign levelOut = out_ff;
endmodule

// >>> rtl/hpc_fifo.sv
// Purpose: Write buffer between host port and internal memory
// Assumes: Single clock, DEPTH a power of two
// Notes: Output word is registered; count covers the array only
`timescale 1ns/1ps
module hpc_fifo #(
  parameter int W = 64,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [W-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

  logic [W-1:0] mem_ff [DEPTH];
  logic [PW-1:0] wrPtr_ff;
  logic [PW-1:0] rdPtr_ff;
  logic [CW-1:0] count_ff;
  logic outValid_ff;
  logic [W-1:0] outData_ff;
  logic push;
  logic pop;

  assign inReady = (count_ff != DEPTH_C);
  assign push = inValid && inReady;
  assign pop = (count_ff != '0) && (!outValid_ff || outReady);

  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wrPtr_ff] <= inData;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wrPtr_ff <= wrPtr_ff + PW'(1);
      end
      if (pop) begin
        rdPtr_ff <= rdPtr_ff + PW'(1);
      end
      if (push && !pop) begin
        count_ff <= count_ff + CW'(1);
      end else if (pop && !push) begin
        count_ff <= count_ff - CW'(1);
      end
    end
  end

  // Output stage refills whenever it empties or is taken
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      outValid_ff <= 1'b0;
      outData_ff <= '0;
    end else if (pop) begin
      outValid_ff <= 1'b1;
      outData_ff <= mem_ff[rdPtr_ff];
    end else if (outReady) begin
      outValid_ff <= 1'b0;
    end
  end

  assign outValid = outValid_ff;
  assign outData = outData_ff;
endmodule

// >>> rtl/hpc_host_port.sv
// Purpose: Parallel host port with CPU-side control registers
// Assumes: Host pins asynchronous to clk; memory side on clk
// Notes: Host writes are buffered, host reads fetch one word
`timescale 1ns/1ps
module hpc_host_port
  import hpc_pkg::*;
#(
  parameter int FIFO_DEPTH = `HPC_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Host strobes and qualifiers
  input wire logic hostChipSelect,
  input wire logic dataStrobeOne,
  input wire logic dataStrobeTwo,
  input wire logic addrStrobe,
  input wire logic [1:0] accessTypeSelect,
  input wire logic readWriteSelect,
  input wire logic halfwordSelect,
  input wire logic widthStrapPin,
  // Host data bus and ready
  input wire logic [31:0] hostDataIn,
  output logic [31:0] hostDataOut,
  output logic hostDataOe,
  output logic hostReadyOut_n,
  // CPU register port
  input wire logic [31:0] cpuAddr,
  input wire logic cpuWrEn,
  input wire logic cpuRdEn,
  input wire logic [31:0] cpuWrData,
  output logic [31:0] cpuRdData,
  output logic cpuRdValid,
  // Interrupts and DMA event
  output logic interruptToHost,
  output logic interruptFromHost,
  output logic dmaEventCh0,
  // Internal memory write path
  output logic memWrValid,
  input wire logic memWrReady,
  output hpc_wr_t memWrBeat,
  // Internal memory read path
  output logic memRdReq,
  output logic [31:0] memRdAddr,
  input wire logic memRdValid,
  input wire logic [31:0] memRdData
);
  // Place a halfword into its lane of a word
  function automatic logic [31:0] placeHalf(logic [15:0] h, logic hi);
    placeHalf = hi ? {h, 16'h0000} : {16'h0000, h};
  endfunction

  // Replace one halfword of a word
  function automatic logic [31:0] mergeHalf(logic [31:0] w,
                                            logic [15:0] h, logic hi);
    mergeHalf = hi ? {h, w[15:0]} : {w[31:16], h};
  endfunction

  // Host-visible lane of a word in the current width
  function automatic logic [31:0] readLane(logic [31:0] w, logic wide,
                                           logic hi);
    if (wide) begin
      readLane = w;
    end else begin
      readLane = {16'h0000, hi ? w[31:16] : w[15:0]};
    end
  endfunction

  logic [8:0] pinSync;
  logic [31:0] dataSync;
  logic csS, ds1S, ds2S, asS, strapS;
  hpc_qual_t pinQual, curQual, qual_ff, acc_ff;
  logic strobeN, strobeN_ff, strobeFall, strobeRise;
  logic asPrev_ff, asFall, asHeld_ff;
  logic [2:0] strapCnt_ff;
  logic strapDone_ff, portWide_ff;
  hpc_state_t state_ff, nxt_state;
  logic [31:0] pwr_ff, wrAddr_ff, rdAddr_ff, rdWord_ff, ctrlView;
  logic [31:0] addrView, wrWord, pulseBits, hostDataOut_ff, ctrlMerged;
  logic [15:0] lowHold_ff;
  logic dual_ff, aSel_ff, toHost_ff, fromHost_ff, dmaEv_ff;
  logic readyN_ff, oe_ff, rdReq_ff;
  logic [31:0] cpuRdData_ff;
  logic cpuRdValid_ff;
  logic isData, wordDone, hostWr, hostCtrlWr, hostAddrWr, pushWr;
  logic fifoInReady, cpuCtrlWr, setFrom, clrTo, rdFetch;

  hpc_sync #(.W(9), .RST(`HPC_RST_PINS)) u_pinSync (
    .clk(clk),
    .rstn(rstn),
    .pinIn({hostChipSelect, dataStrobeOne, dataStrobeTwo, addrStrobe,
            widthStrapPin, accessTypeSelect, readWriteSelect,
            halfwordSelect}),
    .levelOut(pinSync)
  );

  hpc_sync #(.W(32), .RST(`HPC_RST_WORD)) u_dataSync (
    .clk(clk),
    .rstn(rstn),
    .pinIn(hostDataIn),
    .levelOut(dataSync)
  );

  assign {csS, ds1S, ds2S, asS, strapS} = pinSync[8:4];
  assign pinQual = hpc_qual_t'(pinSync[3:0]);

  assign strobeN = ~(ds1S ^ ds2S) | csS;
  assign strobeFall = strobeN_ff && !strobeN;
  assign strobeRise = !strobeN_ff && strobeN;
  assign asFall = asPrev_ff && !asS;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      strobeN_ff <= 1'b1;
      asPrev_ff <= 1'b1;
    end else begin
      strobeN_ff <= strobeN;
      asPrev_ff <= asS;
    end
  end

  // strap taken once the synchroniser has settled
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      strapCnt_ff <= '0;
      strapDone_ff <= 1'b0;
      portWide_ff <= 1'b0;
    end else if (!strapDone_ff) begin
      strapCnt_ff <= strapCnt_ff + 3'h1;
      if (strapCnt_ff == `HPC_STRAP_SETTLE) begin
        strapDone_ff <= 1'b1;
        portWide_ff <= strapS;
      end
    end
  end

  // qualifier latch on address strobe or combined strobe
  assign curQual = asHeld_ff ? qual_ff : pinQual;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      qual_ff <= '0;
      asHeld_ff <= 1'b0;
    end else if (asFall) begin
      qual_ff <= pinQual;
      asHeld_ff <= 1'b1;
    end else if (strobeRise) begin
      asHeld_ff <= 1'b0;
    end
  end

  assign isData = curQual.accessType[0];
  assign wordDone = portWide_ff || acc_ff.halfword;

  // Access sequencing; an early strobe release abandons the access
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (strobeFall && strapDone_ff) begin
          if (!isData || (!portWide_ff && curQual.halfword &&
              curQual.readWrite) ||
              (!portWide_ff && !curQual.halfword && !curQual.readWrite)) begin
            nxt_state = ST_READY;
          end else begin
            nxt_state = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        if (strobeRise) begin
          nxt_state = ST_IDLE;
        end else if (acc_ff.readWrite ? memRdValid : fifoInReady) begin
          nxt_state = ST_READY;
        end
      end
      ST_READY: begin
        if (strobeRise) begin
          nxt_state = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= ST_IDLE;
      acc_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == ST_IDLE && strobeFall) begin
        acc_ff <= curQual;
      end
    end
  end

  // pacing by the ready pin alone
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      readyN_ff <= 1'b1;
      oe_ff <= 1'b0;
    end else begin
      readyN_ff <= (nxt_state != ST_READY);
      oe_ff <= (nxt_state != ST_IDLE) &&
               (state_ff == ST_IDLE ? curQual.readWrite : acc_ff.readWrite);
    end
  end

  // ready bit position always reads zero
  always_comb begin
    ctrlView = `HPC_RST_WORD;
    ctrlView[`HPC_BIT_FROMHOST] = fromHost_ff;
    ctrlView[`HPC_BIT_TOHOST] = toHost_ff;
    ctrlView[`HPC_BIT_READY] = 1'b0;
    ctrlView[`HPC_BIT_DUAL] = dual_ff;
    ctrlView[`HPC_BIT_ASEL] = aSel_ff;
  end

  // host sees one shared or two selectable address registers
  assign addrView = (dual_ff && aSel_ff) ? rdAddr_ff : wrAddr_ff;

  // Host writes take effect when the strobe rises
  assign hostWr = strobeRise && state_ff == ST_READY && !acc_ff.readWrite;
  assign hostCtrlWr = hostWr && acc_ff.accessType == `HPC_AT_CTRL;
  assign hostAddrWr = hostWr && acc_ff.accessType == `HPC_AT_ADDR;
  assign pushWr = hostWr && acc_ff.accessType[0] && wordDone;
  assign wrWord = portWide_ff ? dataSync
                  : {dataSync[15:0], lowHold_ff};
  assign pulseBits = portWide_ff ? dataSync
                     : placeHalf(dataSync[15:0], acc_ff.halfword);
  assign ctrlMerged = portWide_ff ? dataSync
                      : mergeHalf(ctrlView, dataSync[15:0], acc_ff.halfword);
  assign cpuCtrlWr = cpuWrEn && cpuAddr == `HPC_OFS_CTRL;
  assign rdFetch = state_ff == ST_WAIT && acc_ff.readWrite && memRdValid;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lowHold_ff <= '0;
    end else if (hostWr && acc_ff.accessType[0] && !wordDone) begin
      lowHold_ff <= dataSync[15:0];
    end
  end

  // control fields written from either side, host first
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dual_ff <= 1'b0;
      aSel_ff <= 1'b0;
    end else if (hostCtrlWr) begin
      dual_ff <= ctrlMerged[`HPC_BIT_DUAL];
      aSel_ff <= ctrlMerged[`HPC_BIT_ASEL];
    end else if (cpuCtrlWr) begin
      dual_ff <= cpuWrData[`HPC_BIT_DUAL];
      aSel_ff <= cpuWrData[`HPC_BIT_ASEL];
    end
  end

  // host interrupt request and boot-end DMA event
  assign setFrom = hostCtrlWr && pulseBits[`HPC_BIT_FROMHOST];
  // CPU raises host interrupt; host clears it by writing 1
  assign clrTo = hostCtrlWr && pulseBits[`HPC_BIT_TOHOST];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fromHost_ff <= 1'b0;
      toHost_ff <= 1'b0;
      dmaEv_ff <= 1'b0;
    end else begin
      dmaEv_ff <= setFrom;
      // CPU acknowledge loses to a same-cycle host request
      if (setFrom) begin
        fromHost_ff <= 1'b1;
      end else if (cpuCtrlWr && cpuWrData[`HPC_BIT_FROMHOST]) begin
        fromHost_ff <= 1'b0;
      end
      if (cpuCtrlWr && cpuWrData[`HPC_BIT_TOHOST]) begin
        toHost_ff <= 1'b1;
      end else if (clrTo) begin
        toHost_ff <= 1'b0;
      end
    end
  end

  // only host loads and auto-increment move the address registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrAddr_ff <= `HPC_RST_WORD;
      rdAddr_ff <= `HPC_RST_WORD;
    end else if (hostAddrWr) begin
      if (!dual_ff || !aSel_ff) begin
        wrAddr_ff <= portWide_ff ? dataSync
          : mergeHalf(addrView, dataSync[15:0], acc_ff.halfword);
      end
      if (!dual_ff || aSel_ff) begin
        rdAddr_ff <= portWide_ff ? dataSync
          : mergeHalf(addrView, dataSync[15:0], acc_ff.halfword);
      end
    end else if (pushWr && acc_ff.accessType == `HPC_AT_DATAINC) begin
      wrAddr_ff <= wrAddr_ff + `HPC_ADDR_STEP;
      if (!dual_ff) begin
        rdAddr_ff <= wrAddr_ff + `HPC_ADDR_STEP;
      end
    end else if (rdFetch && acc_ff.accessType == `HPC_AT_DATAINC) begin
      rdAddr_ff <= rdAddr_ff + `HPC_ADDR_STEP;
      if (!dual_ff) begin
        wrAddr_ff <= rdAddr_ff + `HPC_ADDR_STEP;
      end
    end
  end

  // Memory read request and host read data
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdReq_ff <= 1'b0;
      rdWord_ff <= `HPC_RST_WORD;
      hostDataOut_ff <= `HPC_RST_WORD;
    end else begin
      rdReq_ff <= state_ff == ST_IDLE && nxt_state == ST_WAIT &&
                  curQual.readWrite;
      if (rdFetch) begin
        rdWord_ff <= memRdData;
        hostDataOut_ff <= readLane(memRdData, portWide_ff, 1'b0);
      end else if (state_ff == ST_IDLE && nxt_state == ST_READY &&
                   curQual.readWrite) begin
        unique case (curQual.accessType)
          `HPC_AT_CTRL: hostDataOut_ff <= readLane(ctrlView, portWide_ff,
                                                   curQual.halfword);
          `HPC_AT_ADDR: hostDataOut_ff <= readLane(addrView, portWide_ff,
                                                   curQual.halfword);
          default: hostDataOut_ff <= readLane(rdWord_ff, portWide_ff,
                                              1'b1);
        endcase
      end
    end
  end

  // CPU reads, address registers as separate locations
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pwr_ff <= `HPC_RST_WORD;
      cpuRdData_ff <= `HPC_RST_WORD;
      cpuRdValid_ff <= 1'b0;
    end else begin
      if (cpuWrEn && cpuAddr == `HPC_OFS_PWR) begin
        pwr_ff <= cpuWrData;
      end
      cpuRdValid_ff <= cpuRdEn;
      if (cpuRdEn) begin
        unique case (cpuAddr)
          `HPC_OFS_PWR: cpuRdData_ff <= pwr_ff;
          `HPC_OFS_CTRL: cpuRdData_ff <= ctrlView;
          `HPC_OFS_WADDR: cpuRdData_ff <= wrAddr_ff;
          `HPC_OFS_RADDR: cpuRdData_ff <= rdAddr_ff;
          default: cpuRdData_ff <= `HPC_RST_WORD;
        endcase
      end
    end
  end

  hpc_fifo #(.W($bits(hpc_wr_t)), .DEPTH(FIFO_DEPTH)) u_wrFifo (
    .clk(clk),
    .rstn(rstn),
    .inValid(pushWr),
    .inReady(fifoInReady),
    .inData({wrAddr_ff, wrWord}),
    .outValid(memWrValid),
    .outReady(memWrReady),
    .outData(memWrBeat)
  );

  assign hostDataOut = hostDataOut_ff;
  assign hostDataOe = oe_ff;
  assign hostReadyOut_n = readyN_ff;
  assign cpuRdData = cpuRdData_ff;
  assign cpuRdValid = cpuRdValid_ff;
  assign interruptToHost = toHost_ff;
  assign interruptFromHost = fromHost_ff;
  assign dmaEventCh0 = dmaEv_ff;
  assign memRdReq = rdReq_ff;
  assign memRdAddr = rdAddr_ff;
endmodule

// >>> verif/hpc_host_port_properties.sv
// Purpose: Port properties of the host parallel port
// Assumes: Bound into hpc_host_port
// Notes: A quiet-strobe counter covers the idle pins
`timescale 1ns/1ps
`include "hpc_params.svh"
module hpc_host_port_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Host side
  input wire logic hostChipSelect,
  input wire logic dataStrobeOne,
  input wire logic dataStrobeTwo,
  input wire logic hostDataOe,
  input wire logic hostReadyOut_n,
  // CPU side
  input wire logic [31:0] cpuAddr,
  input wire logic cpuWrEn,
  input wire logic cpuRdEn,
  input wire logic [31:0] cpuWrData,
  input wire logic [31:0] cpuRdData,
  input wire logic cpuRdValid,
  // Events and memory
  input wire logic interruptToHost,
  input wire logic interruptFromHost,
  input wire logic dmaEventCh0,
  input wire logic [31:0] memRdAddr
);
  logic [3:0] quietCnt_ff;
  logic idle;
  logic wrCtrl;
  logic wrAddr;
  assign idle = ~(dataStrobeOne ^ dataStrobeTwo) | hostChipSelect;
  assign wrCtrl = cpuWrEn && cpuAddr == `HPC_OFS_CTRL;
  assign wrAddr = cpuWrEn && (cpuAddr == `HPC_OFS_WADDR ||
    cpuAddr == `HPC_OFS_RADDR);
  // Cycles since the combined strobe went inactive
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      quietCnt_ff <= 4'h0;
    end else if (!idle) begin
      quietCnt_ff <= 4'h0;
    end else if (quietCnt_ff != 4'hf) begin
      quietCnt_ff <= quietCnt_ff + 4'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_rdValid; cpuRdEn |=> cpuRdValid; endproperty
  a_rdValid: assert property (p_rdValid)
    else $error("read answer missing");
  property p_rdOnly; cpuRdValid |-> $past(cpuRdEn); endproperty
  a_rdOnly: assert property (p_rdOnly)
    else $error("read answer without request");
  property p_noReady;
    cpuRdEn && cpuAddr == `HPC_OFS_CTRL |=> !cpuRdData[3];
  endproperty
  a_noReady: assert property (p_noReady)
    else $error("ready bit reads one");
  property p_toHost; wrCtrl && cpuWrData[2] |=> interruptToHost; endproperty
  a_toHost: assert property (p_toHost)
    else $error("host interrupt not raised");
  property p_ack; wrCtrl && cpuWrData[1] |=> !interruptFromHost; endproperty
  a_ack: assert property (p_ack)
    else $error("host request not cleared");
  property p_addrRo; wrAddr |=> $stable(memRdAddr); endproperty
  a_addrRo: assert property (p_addrRo)
    else $error("cpu changed address register");
  property p_dmaPulse; dmaEventCh0 |=> !dmaEventCh0; endproperty
  a_dmaPulse: assert property (p_dmaPulse)
    else $error("dma event longer than a cycle");
  property p_quiet; quietCnt_ff >= 4'ha |-> hostReadyOut_n && !hostDataOe;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("port active with strobe idle");
endmodule

bind hpc_host_port hpc_host_port_properties hpc_host_port_properties_i (
  .clk, .rstn, .hostChipSelect, .dataStrobeOne, .dataStrobeTwo,
  .hostDataOe, .hostReadyOut_n, .cpuAddr, .cpuWrEn, .cpuRdEn, .cpuWrData,
  .cpuRdData, .cpuRdValid, .interruptToHost, .interruptFromHost,
  .dmaEventCh0, .memRdAddr);

// >>> verif/hpc_host_model.sv
// Purpose: Behavioural host processor on the port pins
// Assumes: Accesses are issued through the access task
// Notes: The data bus changes once the host lets go of it
`timescale 1ns/1ps
module hpc_host_model (
  // Clock and device answers
  input wire logic clk,
  input wire logic hostReadyOut_n,
  input wire logic [31:0] hostDataOut,
  // Host pins
  output logic hostChipSelect,
  output logic dataStrobeOne,
  output logic dataStrobeTwo,
  output logic addrStrobe,
  output logic [1:0] accessTypeSelect,
  output logic readWriteSelect,
  output logic halfwordSelect,
  output logic [31:0] hostDataIn
);
  initial begin
    hostChipSelect = 1'b1;
    dataStrobeOne = 1'b1;
    dataStrobeTwo = 1'b1;
    addrStrobe = 1'b1;
    accessTypeSelect = 2'h0;
    readWriteSelect = 1'b1;
    halfwordSelect = 1'b0;
    hostDataIn = 32'h0;
  end
  task automatic access(input logic useAs, input logic useTwo,
    input logic [1:0] at, input logic rw, input logic hw,
    input logic [31:0] wd, output logic [31:0] rd, output logic ok);
    int n;
    @(posedge clk);
    accessTypeSelect <= at;
    readWriteSelect <= rw;
    halfwordSelect <= hw;
    hostDataIn <= rw ? ~hostDataIn : wd;
    hostChipSelect <= 1'b0;
    if (useAs) begin
      addrStrobe <= 1'b0;
      repeat (8) @(posedge clk);
      accessTypeSelect <= ~at;
      readWriteSelect <= ~rw;
    end
    @(posedge clk);
    if (useTwo) begin
      dataStrobeTwo <= 1'b0;
    end else begin
      dataStrobeOne <= 1'b0;
    end
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hostReadyOut_n !== 1'b0 && n < 300);
    rd = hostDataOut;
    ok = n < 300;
    dataStrobeOne <= 1'b1;
    dataStrobeTwo <= 1'b1;
    hostChipSelect <= 1'b1;
    addrStrobe <= 1'b1;
    repeat (8) @(posedge clk);
    hostDataIn <= ~hostDataIn;
  endtask
endmodule

// >>> verif/tb.sv
// Purpose: Self-checking bench for the host parallel port
// Assumes: Host pins come from hpc_host_model
// Notes: Memory answers a read four cycles after the request
`timescale 1ns/1ps
`include "hpc_params.svh"
module tb
  import hpc_pkg::*;
;
  logic clk, rstn, widthStrapPin, cpuWrEn, cpuRdEn, memWrReady, memRdValid;
  logic hostChipSelect, dataStrobeOne, dataStrobeTwo, addrStrobe;
  logic readWriteSelect, halfwordSelect, hostDataOe, hostReadyOut_n;
  logic cpuRdValid, interruptToHost, interruptFromHost, dmaEventCh0;
  logic memWrValid, memRdReq;
  logic [1:0] accessTypeSelect;
  logic [2:0] rdDly;
  logic [31:0] hostDataIn, hostDataOut, cpuAddr, cpuWrData, cpuRdData;
  logic [31:0] memRdAddr, memRdData, rd;
  hpc_wr_t memWrBeat;
  int failures, checks_done, dmaCnt, n0;
  localparam logic [31:0] KEY = 32'hc3c3_0000;
  hpc_host_port hpc_host_port_i (.clk, .rstn, .hostChipSelect,
    .dataStrobeOne, .dataStrobeTwo, .addrStrobe, .accessTypeSelect,
    .readWriteSelect, .halfwordSelect, .widthStrapPin, .hostDataIn,
    .hostDataOut, .hostDataOe, .hostReadyOut_n, .cpuAddr, .cpuWrEn,
    .cpuRdEn, .cpuWrData, .cpuRdData, .cpuRdValid, .interruptToHost,
    .interruptFromHost, .dmaEventCh0, .memWrValid, .memWrReady,
    .memWrBeat, .memRdReq, .memRdAddr, .memRdValid, .memRdData);
  hpc_host_model hpc_host_model_i (.clk, .hostReadyOut_n, .hostDataOut,
    .hostChipSelect, .dataStrobeOne, .dataStrobeTwo, .addrStrobe,
    .accessTypeSelect, .readWriteSelect, .halfwordSelect, .hostDataIn);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    {rstn, cpuWrEn, cpuRdEn, memWrReady, memRdValid, rdDly} = '0;
    {widthStrapPin, cpuAddr, cpuWrData, memRdData} = {1'b1, 96'h0};
  end
  always @(posedge clk) begin
    rdDly <= {rdDly[1:0], memRdReq};
    memRdValid <= rdDly[2];
    memRdData <= rdDly[2] ? memRdAddr ^ KEY : ~memRdData;
    if (dmaEventCh0) dmaCnt <= dmaCnt + 1;
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic cpuWr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    cpuWrEn <= 1'b1;
    cpuAddr <= a;
    cpuWrData <= d;
    @(posedge clk);
    cpuWrEn <= 1'b0;
  endtask
  task automatic cpuChk(input logic [31:0] a, input logic [31:0] exp);
    @(posedge clk);
    cpuRdEn <= 1'b1;
    cpuAddr <= a;
    @(posedge clk);
    cpuRdEn <= 1'b0;
    #1;
    check(cpuRdValid, 1'b1);
    check(cpuRdData, exp);
  endtask
  task automatic hx(input logic as, input logic two, input logic [1:0] at,
    input logic rw, input logic hw, input logic [31:0] wd);
    logic ok;
    hpc_host_model_i.access(as, two, at, rw, hw, wd, rd, ok);
    check(ok, 1'b1);
  endtask
  task automatic doReset(input logic strap);
    @(posedge clk);
    rstn <= 1'b0;
    widthStrapPin <= strap;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (12) @(posedge clk);
  endtask
  task automatic t_regs();
    cpuChk(`HPC_OFS_CTRL, `HPC_RST_WORD);
    cpuChk(`HPC_OFS_RADDR, `HPC_RST_WORD);
    cpuChk(`HPC_OFS_PWR, `HPC_RST_WORD);
    cpuWr(32'h0288_0000, 32'hffff_ffff);
    cpuChk(32'h0288_0000, 32'h0);
    cpuWr(`HPC_OFS_PWR, 32'ha5a5_0f0f);
    cpuWr(`HPC_OFS_CTRL, 32'h0000_0108);
    cpuChk(`HPC_OFS_CTRL, 32'h0000_0100);
    hx(1'b0, 1'b0, `HPC_AT_CTRL, 1'b1, 1'b0, 32'h0);
    check(rd, 32'h0000_0100);
    hx(1'b0, 1'b0, `HPC_AT_CTRL, 1'b0, 1'b0, 32'h0);
    cpuChk(`HPC_OFS_CTRL, 32'h0);
    cpuChk(`HPC_OFS_PWR, 32'ha5a5_0f0f);
  endtask
  task automatic t_addr();
    hx(1'b1, 1'b1, `HPC_AT_ADDR, 1'b0, 1'b0, 32'h0012_1000);
    cpuChk(`HPC_OFS_WADDR, 32'h0012_1000);
    cpuWr(`HPC_OFS_RADDR, 32'hffff_ffff);
    cpuChk(`HPC_OFS_RADDR, 32'h0012_1000);
    hx(1'b0, 1'b0, `HPC_AT_CTRL, 1'b0, 1'b0, 32'h0000_0100);
    hx(1'b0, 1'b1, `HPC_AT_ADDR, 1'b0, 1'b0, 32'h0034_2000);
    hx(1'b0, 1'b0, `HPC_AT_CTRL, 1'b0, 1'b0, 32'h0000_0900);
    hx(1'b0, 1'b0, `HPC_AT_ADDR, 1'b0, 1'b0, 32'h0056_3000);
    cpuChk(`HPC_OFS_WADDR, 32'h0034_2000);
    cpuChk(`HPC_OFS_RADDR, 32'h0056_3000);
    hx(1'b0, 1'b0, `HPC_AT_ADDR, 1'b1, 1'b0, 32'h0);
    check(rd, 32'h0056_3000);
  endtask
  task automatic t_mem();
    hx(1'b0, 1'b0, `HPC_AT_DATA, 1'b0, 1'b0, 32'h1111_0001);
    hx(1'b0, 1'b0, `HPC_AT_DATAINC, 1'b0, 1'b0, 32'h1111_0002);
    check(memWrBeat, {32'h0034_2000, 32'h1111_0001});
    @(posedge clk);
    memWrReady <= 1'b1;
    n0 = 1;
    repeat (20) begin
      @(posedge clk);
      if (memWrValid && memWrReady) begin
        check(memWrBeat.data, 32'h1111_0000 + n0);
        n0++;
      end
    end
    check(n0, 3);
    hx(1'b0, 1'b0, `HPC_AT_DATA, 1'b1, 1'b0, 32'h0);
    check(rd, 32'h0056_3000 ^ KEY);
  endtask
  task automatic t_irq();
    cpuWr(`HPC_OFS_CTRL, 32'h0000_0904);
    @(posedge clk);
    #1 check(interruptToHost, 1'b1);
    hx(1'b0, 1'b0, `HPC_AT_CTRL, 1'b0, 1'b0, 32'h0000_0904);
    check(interruptToHost, 1'b0);
    n0 = dmaCnt;
    hx(1'b0, 1'b0, `HPC_AT_CTRL, 1'b0, 1'b0, 32'h0000_0902);
    check(dmaCnt - n0, 1);
    check(interruptFromHost, 1'b1);
    cpuWr(`HPC_OFS_CTRL, 32'h0000_0902);
    @(posedge clk);
    #1 check(interruptFromHost, 1'b0);
  endtask
  task automatic t_narrow();
    hx(1'b0, 1'b0, `HPC_AT_ADDR, 1'b0, 1'b0, 32'h0000_beef);
    hx(1'b0, 1'b0, `HPC_AT_ADDR, 1'b0, 1'b1, 32'h0000_1234);
    cpuChk(`HPC_OFS_WADDR, 32'h1234_beef);
    hx(1'b0, 1'b0, `HPC_AT_ADDR, 1'b1, 1'b1, 32'h0);
    check(rd[15:0], 16'h1234);
  endtask
  task automatic final_report();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    doReset(1'b1);
    t_regs();
    t_addr();
    t_mem();
    t_irq();
    doReset(1'b0);
    t_narrow();
    final_report();
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    final_report();
  end
endmodule
